// ---- core/sat_defines.vh ----
// Constants for the split auto-reload timer: bus offsets, field positions,
// reset values and clock divider figures.
// Assumes inclusion by bare name from the timer core, its checker and bench.
`ifndef SAT_DEFINES_VH
`define SAT_DEFINES_VH

// Byte addresses on the AXI4-Lite bus, one aligned word each
`define SAT_ADDR_W 8
`define SAT_OFF_CTRL 8'h00
`define SAT_OFF_RLD_LO 8'h04
`define SAT_OFF_RLD_HI 8'h08
`define SAT_OFF_CNT_LO 8'h0C
`define SAT_OFF_CNT_HI 8'h10
`define SAT_OFF_CLKCTL 8'h14
`define SAT_OFF_EIE 8'h18
`define SAT_OFF_CAPEN 8'h1C
`define SAT_OFF_IRQ_STAT 8'h20
`define SAT_OFF_IRQ_MASK 8'h24

// Control register fields
`define SAT_CTRL_HOVF 7
`define SAT_CTRL_LOVF 6
`define SAT_CTRL_LOIE 5
`define SAT_CTRL_SPLIT 3
`define SAT_CTRL_RUN 2
`define SAT_CTRL_XCLK 0

// Clock control, enable, capture, status and mask fields
`define SAT_CLK_LO_FAST 0
`define SAT_CLK_HI_FAST 1
`define SAT_EIE_TMR 0
`define SAT_CAP_EN 0
`define SAT_ST_HOVF 0
`define SAT_ST_LOVF 1

// Reset values and terminal counts
`define SAT_BYTE_RST 8'h00
`define SAT_MASK_RST 2'h3
`define SAT_BYTE_MAX 8'hFF
`define SAT_WORD_MAX 16'hFFFF

// Clock dividers
`define SAT_DIV_SYS 12
`define SAT_DIV_EXT 8
`define SAT_DIV_W 4

// AXI responses
`define SAT_RESP_OKAY 2'h0
`define SAT_RESP_SLVERR 2'h2

`endif

// ---- core/sat_timer.v ----
// Split auto-reload timer: 16-bit up-counter or two 8-bit counters, with an
// AXI4-Lite register slave, clock prescalers and one level interrupt.
// Assumes a single clock aclk, a synchronous active-low reset and an
// external oscillator pin that is asynchronous to aclk.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`include "sat_defines.vh"

module sat_timer #(
    parameter DIV_SYS = `SAT_DIV_SYS,
    parameter DIV_EXT = `SAT_DIV_EXT
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire ext_osc,
    input wire [`SAT_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`SAT_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire irq
);

    // Byte step with auto-reload: {wrapped, next value}
    function [8:0] sat_step;
        input [7:0] cur;
        input [7:0] rld;
        begin
            if (cur == `SAT_BYTE_MAX)
                sat_step = {1'b1, rld};
            else
                sat_step = {1'b0, cur + 8'h01};
        end
    endfunction

    // Address decode shared by write and read paths
    function sat_mapped;
        input [`SAT_ADDR_W-1:0] a;
        begin
            case (a)
                `SAT_OFF_CTRL, `SAT_OFF_RLD_LO, `SAT_OFF_RLD_HI, `SAT_OFF_CNT_LO,
                `SAT_OFF_CNT_HI, `SAT_OFF_CLKCTL, `SAT_OFF_EIE, `SAT_OFF_CAPEN,
                `SAT_OFF_IRQ_STAT, `SAT_OFF_IRQ_MASK: sat_mapped = 1'b1;
                default: sat_mapped = 1'b0;
            endcase
        end
    endfunction

    // Last prescaler states, cut to the counter width on purpose
    localparam integer SYS_LAST_I = DIV_SYS - 1;
    localparam integer EXT_LAST_I = DIV_EXT - 1;
    localparam [`SAT_DIV_W-1:0] SYS_LAST = SYS_LAST_I[`SAT_DIV_W-1:0];
    localparam [`SAT_DIV_W-1:0] EXT_LAST = EXT_LAST_I[`SAT_DIV_W-1:0];

    // Register state
    reg hovf_q, lovf_q, loie_q, split_q, run_q, xclk_q;
    reg [7:0] rld_lo_q, rld_hi_q, cnt_lo_q, cnt_hi_q;
    reg lo_fast_q, hi_fast_q, eie_q, cap_q;
    reg [1:0] mask_q;
    reg irq_q;

    // Prescaler and synchroniser state
    reg [`SAT_DIV_W-1:0] div_sys_q, div_ext_q;
    reg osc_s1_q, osc_s2_q, osc_s3_q;

    // Bus state
    reg aw_have_q, w_have_q, bvalid_q, rvalid_q;
    reg [`SAT_ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q, rdata_q;
    reg [3:0] wstrb_q;
    reg [1:0] bresp_q, rresp_q;

    // Handshakes: one write and one read under way at most
    assign s_axi_awready = ce & ~aw_have_q & ~bvalid_q;
    assign s_axi_wready = ce & ~w_have_q & ~bvalid_q;
    assign s_axi_arready = ce & ~rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = irq_q;

    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire ar_fire = s_axi_arvalid & s_axi_arready;
    wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
    wire wr_lane0 = wr_go & wstrb_q[0];
    wire [7:0] wb = wdata_q[7:0];

    // Per-register write strobes
    wire wr_ctrl = wr_lane0 & (awaddr_q == `SAT_OFF_CTRL);
    wire wr_rll = wr_lane0 & (awaddr_q == `SAT_OFF_RLD_LO);
    wire wr_rlh = wr_lane0 & (awaddr_q == `SAT_OFF_RLD_HI);
    wire wr_cl = wr_lane0 & (awaddr_q == `SAT_OFF_CNT_LO);
    wire wr_ch = wr_lane0 & (awaddr_q == `SAT_OFF_CNT_HI);
    wire wr_clk = wr_lane0 & (awaddr_q == `SAT_OFF_CLKCTL);
    wire wr_eie = wr_lane0 & (awaddr_q == `SAT_OFF_EIE);
    wire wr_cap = wr_lane0 & (awaddr_q == `SAT_OFF_CAPEN);
    wire wr_st = wr_lane0 & (awaddr_q == `SAT_OFF_IRQ_STAT);
    wire wr_msk = wr_lane0 & (awaddr_q == `SAT_OFF_IRQ_MASK);

    // Prescaler ticks; the oscillator edge is taken only after two flops
    wire tick_sys = (div_sys_q == SYS_LAST);
    wire osc_rise = osc_s2_q & ~osc_s3_q;
    wire tick_ext = osc_rise & (div_ext_q == EXT_LAST);
    wire tick_slow = xclk_q ? tick_ext : tick_sys;

    // Per-byte source: fast select wins, else the external select
    wire tick_lo = lo_fast_q | tick_slow;
    wire tick_hi = hi_fast_q | tick_slow;

    // Split needs capture disabled
    wire split_eff = split_q & ~cap_q;

    // Low byte free-runs in split mode; run gates all else
    wire adv_lo = split_eff ? tick_lo : (run_q & tick_lo);
    wire adv_hi = split_eff ? (run_q & tick_hi) : (run_q & tick_lo);

    // Counter arithmetic on the two halves
    wire [8:0] step_lo = sat_step(cnt_lo_q, rld_lo_q);
    wire [8:0] step_hi = sat_step(cnt_hi_q, rld_hi_q);
    wire [15:0] word_q = {cnt_hi_q, cnt_lo_q};
    wire word_wrap = (word_q == `SAT_WORD_MAX);
    wire [15:0] word_next = word_wrap ? {rld_hi_q, rld_lo_q} : (word_q + 16'h0001);

    // Overflow events; low wrap counts in either mode
    wire set_lo = adv_lo & step_lo[8];
    wire set_hi = adv_hi & (split_eff ? step_hi[8] : word_wrap);

    // Read mux; unused control bits read zero
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = `SAT_BYTE_RST;
        case (s_axi_araddr)
            `SAT_OFF_CTRL: rd_byte = {hovf_q, lovf_q, loie_q, 1'b0, split_q, run_q, 1'b0, xclk_q};
            `SAT_OFF_RLD_LO: rd_byte = rld_lo_q;
            `SAT_OFF_RLD_HI: rd_byte = rld_hi_q;
            `SAT_OFF_CNT_LO: rd_byte = cnt_lo_q;
            `SAT_OFF_CNT_HI: rd_byte = cnt_hi_q;
            `SAT_OFF_CLKCTL: rd_byte = {6'h00, hi_fast_q, lo_fast_q};
            `SAT_OFF_EIE: rd_byte = {7'h00, eie_q};
            `SAT_OFF_CAPEN: rd_byte = {7'h00, cap_q};
            `SAT_OFF_IRQ_STAT: rd_byte = {6'h00, lovf_q, hovf_q};
            `SAT_OFF_IRQ_MASK: rd_byte = {6'h00, mask_q};
            default: rd_byte = `SAT_BYTE_RST;
        endcase
    end

    // AXI4-Lite slave; address and data may arrive in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            awaddr_q <= `SAT_BYTE_RST;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bresp_q <= `SAT_RESP_OKAY;
            rresp_q <= `SAT_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else if (ce) begin
            if (aw_fire) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= sat_mapped(awaddr_q) ? `SAT_RESP_OKAY : `SAT_RESP_SLVERR;
            end else if (bvalid_q & s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (ar_fire) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= sat_mapped(s_axi_araddr) ? `SAT_RESP_OKAY : `SAT_RESP_SLVERR;
            end else if (rvalid_q & s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Prescalers and oscillator synchroniser; s1 feeds only s2
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_sys_q <= {`SAT_DIV_W{1'b0}};
            div_ext_q <= {`SAT_DIV_W{1'b0}};
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else if (ce) begin
            osc_s1_q <= ext_osc;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            div_sys_q <= tick_sys ? {`SAT_DIV_W{1'b0}} : (div_sys_q + 1'b1);
            if (osc_rise)
                div_ext_q <= (div_ext_q == EXT_LAST) ? {`SAT_DIV_W{1'b0}} : (div_ext_q + 1'b1);
        end
    end

    // Timer registers: counting first, then software writes override the
    // count, then hardware flag sets override any clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            hovf_q <= 1'b0;
            lovf_q <= 1'b0;
            loie_q <= 1'b0;
            split_q <= 1'b0;
            run_q <= 1'b0;
            xclk_q <= 1'b0;
            rld_lo_q <= `SAT_BYTE_RST;
            rld_hi_q <= `SAT_BYTE_RST;
            cnt_lo_q <= `SAT_BYTE_RST;
            cnt_hi_q <= `SAT_BYTE_RST;
            lo_fast_q <= 1'b0;
            hi_fast_q <= 1'b0;
            eie_q <= 1'b0;
            cap_q <= 1'b0;
            mask_q <= `SAT_MASK_RST;
            irq_q <= 1'b0;
        end else if (ce) begin
            if (split_eff) begin
                if (adv_lo)
                    cnt_lo_q <= step_lo[7:0];
                if (adv_hi)
                    cnt_hi_q <= step_hi[7:0];
            end else if (adv_lo) begin
                cnt_lo_q <= word_next[7:0];
                cnt_hi_q <= word_next[15:8];
            end
            if (wr_cl)
                cnt_lo_q <= wb;
            if (wr_ch)
                cnt_hi_q <= wb;
            if (wr_ctrl) begin
                hovf_q <= wb[`SAT_CTRL_HOVF];
                lovf_q <= wb[`SAT_CTRL_LOVF];
                loie_q <= wb[`SAT_CTRL_LOIE];
                split_q <= wb[`SAT_CTRL_SPLIT];
                run_q <= wb[`SAT_CTRL_RUN];
                xclk_q <= wb[`SAT_CTRL_XCLK];
            end
            // Write-one-to-clear view of the same flags
            if (wr_st & wb[`SAT_ST_HOVF])
                hovf_q <= 1'b0;
            if (wr_st & wb[`SAT_ST_LOVF])
                lovf_q <= 1'b0;
            // Sticky: only software clears, a set in the same cycle wins
            if (set_hi)
                hovf_q <= 1'b1;
            if (set_lo)
                lovf_q <= 1'b1;
            if (wr_rll)
                rld_lo_q <= wb;
            if (wr_rlh)
                rld_hi_q <= wb;
            if (wr_clk) begin
                lo_fast_q <= wb[`SAT_CLK_LO_FAST];
                hi_fast_q <= wb[`SAT_CLK_HI_FAST];
            end
            if (wr_eie)
                eie_q <= wb[`SAT_EIE_TMR];
            if (wr_cap)
                cap_q <= wb[`SAT_CAP_EN];
            if (wr_msk)
                mask_q <= wb[1:0];
            // Level request from flags; registered so the pin is glitch free
            irq_q <= eie_q & ((hovf_q & mask_q[`SAT_ST_HOVF]) |
                              (lovf_q & loie_q & mask_q[`SAT_ST_LOVF]));
        end
    end

endmodule

// ---- tb/sat_timer_chk.sv ----
// Checker for the timer's register bus handshakes.
// Assumes one clock domain and the core's own port names.
`include "sat_defines.vh"
module sat_timer_chk (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`SAT_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Address and data taken together, then one enabled edge to commit
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 ce;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_ctrl_read;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == `SAT_OFF_CTRL);
    endsequence
    a_ctrl_unused: assert property (s_ctrl_read |=> !s_axi_rdata[4] && !s_axi_rdata[1])
        else $error("unused control bits read as one");
    a_b_answer: assert property (s_wr_both |=> s_axi_bvalid)
        else $error("write response late");
    a_r_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write accepted");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
endmodule

bind sat_timer sat_timer_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ---- tb/tb_split_autoreload_timer.sv ----
// Self-checking bench for the split auto-reload timer over AXI4-Lite.
// Assumes the core and its defines header are on the include path.
`include "sat_defines.vh"
module tb_split_autoreload_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic ce = 1'h1;
    logic ext_osc = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic arvalid = 1'h0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] v;
    logic [31:0] w;
    wire awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp;
    wire [31:0] rdata;
    wire [1:0] rresp;
    logic bready = 1'h1;
    logic rready = 1'h1;
    logic [1:0] rresp_seen = 2'h0;
    int fail_count = 0;
    int check_count = 0;

    // Responses are accepted at once unless a task is told to hold them off
    sat_timer u_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .ext_osc(ext_osc),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq)
    );

    // 125 MHz clock
    initial begin
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask

    // Range compare; an unknown value never lands inside
    task automatic rng(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        check_count++;
        if (((g >= lo) && (g <= hi)) !== 1'h1) begin
            fail_count++;
            $display("mismatch %s exp %h..%h got %h", n, lo, hi, g);
        end
    endtask

    // Handshakes are sampled at the falling edge, where the core's outputs are
    // settled, and acted on right after the next rising edge; each channel is
    // released after the edge that takes it, bready optionally held off
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
                      input int hold = 0);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        if (hold > 0) bready <= 1'h0;
        do begin
            @(negedge aclk);
            aw_ok = awvalid & awready;
            w_ok = wvalid & wready;
            b_ok = bvalid & bready;
            r = bresp;
            if (bvalid && !bready) hold--;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
            if (hold <= 0 && !bready) bready <= 1'h1;
        end while (!b_ok);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input int hold = 0);
        logic ar_ok, r_ok;
        araddr <= a;
        arvalid <= 1'h1;
        if (hold > 0) rready <= 1'h0;
        do begin
            @(negedge aclk);
            ar_ok = arvalid & arready;
            r_ok = rvalid & rready;
            d = rdata;
            rresp_seen = rresp;
            if (rvalid && !rready) hold--;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'h0;
            if (hold <= 0 && !rready) rready <= 1'h1;
        end while (!r_ok);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0,
                       input int hold = 0);
        logic [31:0] d;
        rd(a, d, hold);
        chk($sformatf("reg %h", a), e, d);
        chk("rresp", {30'h0, er}, {30'h0, rresp_seen});
    endtask

    // The request pin is registered, so it is looked at once settled
    task automatic irq_is(input logic e);
        @(negedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge aclk);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A hang ends the run as a failure
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rdc(`SAT_OFF_CTRL, 32'h00);
        rdc(`SAT_OFF_IRQ_MASK, 32'h03, `SAT_RESP_OKAY, 3);
        wr(`SAT_OFF_CTRL, 32'h12, `SAT_RESP_OKAY, 3);
        rdc(`SAT_OFF_CTRL, 32'h00);
        wr(8'h40, 32'h01, `SAT_RESP_SLVERR);
        rdc(8'h40, 32'h00, `SAT_RESP_SLVERR);
        // 16-bit wrap with a reload near the top keeps the high byte at FF
        wr(`SAT_OFF_CLKCTL, 32'h01);
        wr(`SAT_OFF_EIE, 32'h01);
        wr(`SAT_OFF_RLD_LO, 32'hF0);
        wr(`SAT_OFF_RLD_HI, 32'hFF);
        wr(`SAT_OFF_CNT_LO, 32'hFE);
        wr(`SAT_OFF_CNT_HI, 32'hFF);
        wr(`SAT_OFF_CTRL, 32'h04);
        repeat (40) @(posedge aclk);
        rdc(`SAT_OFF_CTRL, 32'hC4);
        wr(`SAT_OFF_CTRL, 32'hC0);
        rdc(`SAT_OFF_CNT_HI, 32'hFF);
        rd(`SAT_OFF_CNT_LO, v);
        rng("wrap low", 32'hF0, 32'hFF, v);
        rdc(`SAT_OFF_CTRL, 32'hC0);
        irq_is(1'h1);
        wr(`SAT_OFF_IRQ_MASK, 32'h00);
        irq_is(1'h0);
        wr(`SAT_OFF_IRQ_MASK, 32'h03);
        rdc(`SAT_OFF_IRQ_STAT, 32'h03);
        wr(`SAT_OFF_IRQ_STAT, 32'h03);
        rdc(`SAT_OFF_CTRL, 32'h00);
        irq_is(1'h0);
        // Low byte wrap in 16-bit mode carries into the high byte
        wr(`SAT_OFF_CNT_HI, 32'h00);
        wr(`SAT_OFF_CNT_LO, 32'hF0);
        wr(`SAT_OFF_CTRL, 32'h24);
        repeat (30) @(posedge aclk);
        rdc(`SAT_OFF_CNT_HI, 32'h01);
        rdc(`SAT_OFF_CTRL, 32'h64);
        irq_is(1'h1);
        wr(`SAT_OFF_IRQ_MASK, 32'h01);
        irq_is(1'h0);
        wr(`SAT_OFF_CTRL, 32'h00);
        wr(`SAT_OFF_IRQ_MASK, 32'h03);
        // Split mode, high byte stopped while the low byte runs
        wr(`SAT_OFF_CLKCTL, 32'h03);
        wr(`SAT_OFF_CNT_HI, 32'h55);
        wr(`SAT_OFF_CNT_LO, 32'hF0);
        wr(`SAT_OFF_CTRL, 32'h08);
        repeat (40) @(posedge aclk);
        rdc(`SAT_OFF_CNT_HI, 32'h55);
        rdc(`SAT_OFF_CTRL, 32'h48);
        irq_is(1'h0);
        wr(`SAT_OFF_CTRL, 32'h68);
        irq_is(1'h1);
        wr(`SAT_OFF_CNT_HI, 32'hF0);
        wr(`SAT_OFF_CTRL, 32'h0C);
        repeat (40) @(posedge aclk);
        rdc(`SAT_OFF_CTRL, 32'hCC);
        rdc(`SAT_OFF_CNT_HI, 32'hFF);
        rd(`SAT_OFF_CNT_LO, v);
        rng("split low", 32'hF0, 32'hFF, v);
        irq_is(1'h1);
        // Capture enable keeps split off, so nothing counts without run
        wr(`SAT_OFF_CAPEN, 32'h01);
        wr(`SAT_OFF_CTRL, 32'h08);
        wr(`SAT_OFF_CNT_LO, 32'h10);
        repeat (20) @(posedge aclk);
        rdc(`SAT_OFF_CNT_LO, 32'h10);
        wr(`SAT_OFF_CAPEN, 32'h00);
        // Divide by 12, then a frozen stretch with ce low
        wr(`SAT_OFF_CLKCTL, 32'h00);
        wr(`SAT_OFF_CNT_LO, 32'h00);
        wr(`SAT_OFF_CTRL, 32'h04);
        repeat (120) @(posedge aclk);
        rd(`SAT_OFF_CNT_LO, v);
        rng("div12", 32'h09, 32'h0C, v);
        ce <= 1'h0;
        repeat (200) @(posedge aclk);
        ce <= 1'h1;
        rd(`SAT_OFF_CNT_LO, w);
        rng("frozen", v, v + 32'h1, w);
        // Oscillator over 8: 32 rising edges give four counts
        wr(`SAT_OFF_CTRL, 32'h00);
        wr(`SAT_OFF_CNT_LO, 32'h00);
        wr(`SAT_OFF_CTRL, 32'h05);
        repeat (64) begin
            repeat (2) @(posedge aclk);
            ext_osc <= ~ext_osc;
        end
        rd(`SAT_OFF_CNT_LO, v);
        rng("ext8", 32'h03, 32'h04, v);
        wrap_up();
    end
endmodule
